// [core/sled_pkg.sv]
// Shared constants and types of the serial LED segment loader
package sled_pkg;

    // ==========================================================
    // Frame layout
    // ==========================================================
    localparam int FRAME_BITS = 36;
    localparam int DATA_BITS = 35;
    localparam int BIT_IDX_W = 6;
    localparam logic [BIT_IDX_W-1:0] LAST_BIT_IDX = 6'h23;
    localparam logic START_BIT = 1'b1;

    // ==========================================================
    // Reset values
    // ==========================================================
    localparam logic [DATA_BITS-1:0] SEG_RESET = 35'h0;
    localparam logic [FRAME_BITS-1:0] SHREG_RESET = 36'h0;

    // ==========================================================
    // Timing
    // ==========================================================
    localparam int CORE_CLK_PERIOD_NS = 10;
    localparam int SCLK_MIN_PERIOD_NS = 2000;
    localparam int SCLK_PERIOD_CYC =
        (SCLK_MIN_PERIOD_NS + CORE_CLK_PERIOD_NS - 1) / CORE_CLK_PERIOD_NS;
    localparam int HALF_CYC = (SCLK_PERIOD_CYC + 1) / 2;
    localparam int HALF_CNT_W = 8;
    localparam logic [HALF_CNT_W-1:0] HALF_CNT_LOAD = 8'(HALF_CYC - 1);

    // ==========================================================
    // Sender states
    // ==========================================================
    typedef enum logic [3:0]
    {
        SLED_IDLE = 4'h1,
        SLED_LOW = 4'h2,
        SLED_HIGH = 4'h4,
        SLED_TAIL = 4'h8
    } sled_tx_state_t;

endpackage

// [core/sled_link_if.sv]
// Two-wire serial link, plus data enable, between sender and loader
`timescale 1ns/1ns
`default_nettype none

interface sled_link_if;
    logic sclk;
    logic sdata;
    logic data_en;

    modport host
    (
        output sclk,
        output sdata,
        output data_en
    );

    modport device
    (
        input sclk,
        input sdata,
        input data_en
    );
endinterface

`default_nettype wire

// [core/sled_host.sv]
// Sender end: turns a 35-bit word into one framed serial transfer
`timescale 1ns/1ns
`default_nettype none

module sled_host
(
    input wire logic core_clk,
    input wire logic rstn,
    input wire logic send_req,
    input wire logic [sled_pkg::DATA_BITS-1:0] send_data,
    output logic busy,
    sled_link_if.host link
);
    import sled_pkg::*;

    typedef struct packed {
        sled_tx_state_t st;
        logic [HALF_CNT_W-1:0] cnt;
        logic [BIT_IDX_W-1:0] bit_idx;
        logic [FRAME_BITS-1:0] frame;
        logic sclk;
        logic sdata;
        logic den;
    } sled_tx_t;

    sled_tx_t q;
    sled_tx_t d;

    // ==========================================================
    // Frame sequencer
    // ==========================================================
    always_comb
    begin
        d = q;
        if (q.st != SLED_IDLE && q.cnt != '0)
        begin
            d.cnt = q.cnt - 8'h01;
        end
        unique case (q.st)
            SLED_IDLE:
            begin
                if (send_req)
                begin
                    // Start bit first, then output 1 upward
                    d.frame = {send_data, START_BIT};
                    d.sdata = START_BIT;
                    d.den = 1'b1;
                    d.sclk = 1'b0;
                    d.bit_idx = '0;
                    d.cnt = HALF_CNT_LOAD;
                    d.st = SLED_LOW;
                end
            end
            SLED_LOW:
            begin
                if (q.cnt == '0)
                begin
                    d.sclk = 1'b1;
                    d.cnt = HALF_CNT_LOAD;
                    d.st = SLED_HIGH;
                end
            end
            SLED_HIGH:
            begin
                if (q.cnt == '0)
                begin
                    d.sclk = 1'b0;
                    d.cnt = HALF_CNT_LOAD;
                    // Always a full 36 clocks, with data enable held high throughout
                    if (q.bit_idx == LAST_BIT_IDX)
                    begin
                        d.st = SLED_TAIL;
                    end
                    else
                    begin
                        d.frame = {1'b0, q.frame[FRAME_BITS-1:1]};
                        d.sdata = q.frame[1];
                        d.bit_idx = q.bit_idx + 6'h01;
                        d.st = SLED_LOW;
                    end
                end
            end
            SLED_TAIL:
            begin
                // Enable stays up over the low phase that clears the chain
                if (q.cnt == '0)
                begin
                    d.den = 1'b0;
                    d.sdata = 1'b0;
                    d.st = SLED_IDLE;
                end
            end
        endcase
    end

    always_ff @(posedge core_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            q <= '{st: SLED_IDLE, default: '0};
        end
        else
        begin
            q <= d;
        end
    end

    assign busy = (q.st != SLED_IDLE);
    assign link.sclk = q.sclk;
    assign link.sdata = q.sdata;
    assign link.data_en = q.den;

endmodule

`default_nettype wire

// [core/sled_device.sv]
// Loader end: samples the serial link, shifts frames and drives segment latches
`timescale 1ns/1ns
`default_nettype none


module sled_device
#(
    parameter bit USE_DATA_EN = 1'b0
)
(
    input wire logic core_clk,
    input wire logic rstn,
    sled_link_if.device link,
    output logic [sled_pkg::DATA_BITS-1:0] seg_on,
    output logic frame_loaded
);
    import sled_pkg::*;

    // ==========================================================
    // State
    // ==========================================================
    typedef struct packed {
        // Pin samplers, newest in bit 0
        logic [2:0] clk_sync;
        logic [2:0] dat_sync;
        logic [2:0] en_sync;
        // Filtered pin levels
        logic clk_f;
        logic dat_f;
        logic en_f;
        // Stage-one master, shift chain and output latches
        logic master0;
        logic [FRAME_BITS-1:0] shreg;
        logic [DATA_BITS-1:0] seg;
        // Load seen, chain clear still owed
        logic clr_pend;
        logic loaded;
    } sled_dev_t;

    sled_dev_t q;
    sled_dev_t d;

    // ==========================================================
    // Helpers
    // ==========================================================
    // Filtered level: follows the pin once stages two and three agree
    function automatic logic filt_next(input logic [2:0] s, input logic f);
        logic r;
        r = f;
        if (s[1] == s[2])
        begin
            r = s[2];
        end
        return r;
    endfunction

    // Chain holds the start bit at the top; first data bit just below it
    function automatic logic [DATA_BITS-1:0] map_bits(input logic [FRAME_BITS-1:0] sh);
        logic [DATA_BITS-1:0] r;
        r = '0;
        for (int i = 0; i < DATA_BITS; i++)
        begin
            r[i] = sh[DATA_BITS-1-i];
        end
        return r;
    endfunction

    // Edge of the filtered clock toward level lvl, only while listening
    function automatic logic edge_to(input logic en, input logic now, input logic was,
        input logic lvl);
        return en && now == lvl && was != lvl;
    endfunction

    // Outputs really driven; in the enable variant the top one is an input
    function automatic logic [DATA_BITS-1:0] driven_mask();
        logic [DATA_BITS-1:0] m;
        m = '1;
        if (USE_DATA_EN)
        begin
            m[DATA_BITS-1] = 1'b0;
        end
        return m;
    endfunction

    // ==========================================================
    // Next state
    // ==========================================================
    // Only the samplers read the pins; everything else below works on the registered state only
    always_comb
    begin
        logic clk_n;
        logic dat_n;
        logic en_n;
        logic active;
        logic rise;
        logic fall;
        logic [FRAME_BITS-1:0] sh_n;
        logic [DATA_BITS-1:0] lat_n;
        clk_n = 1'b0;
        dat_n = 1'b0;
        en_n = 1'b0;
        active = 1'b0;
        rise = 1'b0;
        fall = 1'b0;
        sh_n = '0;
        lat_n = '0;
        d = q;
        d.loaded = 1'b0;

        // ==========================================================
        // Three-stage samplers on every pin
        d.clk_sync = {q.clk_sync[1:0], link.sclk};
        d.dat_sync = {q.dat_sync[1:0], link.sdata};
        d.en_sync = {q.en_sync[1:0], link.data_en};
        clk_n = filt_next(q.clk_sync, q.clk_f);
        dat_n = filt_next(q.dat_sync, q.dat_f);
        en_n = filt_next(q.en_sync, q.en_f);
        d.clk_f = clk_n;
        d.dat_f = dat_n;
        d.en_f = en_n;

        // ==========================================================
        // Without the enable option the link is always listened to
        active = !USE_DATA_EN || q.en_f;
        rise = edge_to(active, clk_n, q.clk_f, 1'b1);
        fall = edge_to(active, clk_n, q.clk_f, 1'b0);

        // ==========================================================
        // Master of stage one follows data while the clock is low
        // Never cleared by frame end, so frames may follow with no gap
        if (active && !q.clk_f)
        begin
            d.master0 = q.dat_f;
        end

        // ==========================================================
        // Shift on the rising edge; nothing moves otherwise
        sh_n = q.shreg;
        if (rise)
        begin
            sh_n = {q.shreg[FRAME_BITS-2:0], q.master0};
        end
        d.shreg = sh_n;

        // ==========================================================
        // Start bit reached the top: transfer while the clock is high
        if (rise && sh_n[FRAME_BITS-1] == START_BIT)
        begin
            lat_n = map_bits(sh_n) & driven_mask();
            d.seg = lat_n;
            d.loaded = 1'b1;
            d.clr_pend = 1'b1;
        end

        // ==========================================================
        // Low phase after a transfer empties the chain, not the master
        if (fall && q.clr_pend)
        begin
            d.shreg = SHREG_RESET;
            d.clr_pend = 1'b0;
        end
    end

    // ==========================================================
    // Registers
    // ==========================================================
    // Pins reach the filtered levels four cycles after they move
    always_ff @(posedge core_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            q <= '0;
        end
        else
        begin
            q <= d;
        end
    end

    // ==========================================================
    // Outputs
    // ==========================================================
    for (genvar g = 0; g < DATA_BITS; g++)
    begin : g_seg
        assign seg_on[g] = q.seg[g];
    end
    // Load pulse lasts one cycle, the cycle the latches take the frame
    assign frame_loaded = q.loaded;

endmodule

`default_nettype wire

// [verif/sled_link_asserts.sv]
// Concurrent checks on the joined serial link and loader outputs
`timescale 1ns/1ns
`default_nettype none

module sled_link_asserts
(
    input wire logic core_clk,
    input wire logic rstn,
    input wire logic sclk,
    input wire logic sdata,
    input wire logic data_en,
    input wire logic busy,
    input wire logic [sled_pkg::DATA_BITS-1:0] seg_on,
    input wire logic frame_loaded
);
    import sled_pkg::*;

    logic [7:0] half_q;

    default clocking @(posedge core_clk); endclocking
    default disable iff (!rstn);

    // ====
    // Cycles since the serial clock last moved
    always_ff @(posedge core_clk or negedge rstn)
    begin
        if (!rstn)
            half_q <= 8'hff;
        else if ($changed(sclk))
            half_q <= 8'h00;
        else if (half_q != 8'hff)
            half_q <= half_q + 8'h01;
    end

    AST_SEG_HOLD: assert property ($changed(seg_on) |-> frame_loaded)
        else $error("segments moved outside a load");
    AST_LOAD_HIGH: assert property (frame_loaded |-> sclk && data_en)
        else $error("load outside clock high");
    AST_LOAD_PULSE: assert property (frame_loaded |=> !frame_loaded)
        else $error("load pulse too long");
    AST_RESET_OFF: assert property ($rose(rstn) |-> seg_on == 35'h0 && !frame_loaded)
        else $error("outputs on after reset");
    AST_START_HIGH: assert property ($rose(data_en) |-> sdata)
        else $error("frame without start bit");
    AST_HALF_PERIOD: assert property ($changed(sclk) |-> half_q >= 8'h63)
        else $error("serial clock too fast");
    AST_IDLE_STILL: assert property (!data_en |-> !sclk)
        else $error("clock moves between frames");
    AST_BUSY_END: assert property ($fell(busy) |-> !data_en && !sclk)
        else $error("frame ended early");
endmodule

`default_nettype wire

// [verif/serial_led_segment_loader_tb.sv]
// Self-checking bench: sender and loader joined, plus a bench-driven enable variant
`timescale 1ns/1ns
`default_nettype none

module serial_led_segment_loader_tb;
    import sled_pkg::*;

    logic core_clk = 1'b0;
    logic rstn = 1'b0;
    logic send_req = 1'b0;
    logic [DATA_BITS-1:0] send_data = 35'h0;
    logic busy;
    logic frame_loaded;
    logic frame_loaded_en;
    logic [DATA_BITS-1:0] seg_on;
    logic [DATA_BITS-1:0] seg_on_en;
    logic [31:0] lfsr = 32'h15;
    int mismatches = 0;
    int check_count = 0;
    int loads_en = 0;
    bit wire_bits[$];

    sled_link_if link();
    sled_link_if link_en();

    sled_host i_sled_host(.core_clk(core_clk), .rstn(rstn), .send_req(send_req),
        .send_data(send_data), .busy(busy), .link(link));
    sled_device i_sled_device(.core_clk(core_clk), .rstn(rstn), .link(link),
        .seg_on(seg_on), .frame_loaded(frame_loaded));
    sled_device #(.USE_DATA_EN(1'b1)) i_sled_device_en(.core_clk(core_clk), .rstn(rstn),
        .link(link_en), .seg_on(seg_on_en), .frame_loaded(frame_loaded_en));
    sled_link_asserts i_sled_link_asserts(.core_clk(core_clk), .rstn(rstn),
        .sclk(link.sclk), .sdata(link.sdata), .data_en(link.data_en), .busy(busy),
        .seg_on(seg_on), .frame_loaded(frame_loaded));

    initial
    begin
        forever #5 core_clk = ~core_clk;
    end

    always @(posedge link.sclk)
        wire_bits.push_back(link.sdata);

    always @(posedge core_clk)
        if (frame_loaded_en === 1'b1)
            loads_en++;

    // ====
    // Shared tasks
    task automatic check(input string what, input logic [35:0] seen, input logic [35:0] exp);
        check_count++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic finish_test();
        $display("Checks %0d mismatches %0d", check_count, mismatches);
        if (mismatches == 0 && check_count > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    function automatic logic [31:0] lfsr_step(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    task automatic next_word(output logic [DATA_BITS-1:0] w);
        lfsr = lfsr_step(lfsr);
        w[31:0] = lfsr;
        lfsr = lfsr_step(lfsr);
        w[34:32] = lfsr[2:0];
    endtask

    // Bounded wait: 0 for a load, else for busy low
    task automatic wait_on(input int which);
        int n;
        n = 0;
        do
        begin
            @(negedge core_clk);
            n++;
        end
        while (!(which == 0 ? frame_loaded === 1'b1 : busy === 1'b0) && n < 8000);
        if (n >= 8000)
        begin
            mismatches++;
            finish_test();
        end
    endtask

    task automatic send_frame(input logic [DATA_BITS-1:0] w);
        wire_bits = {};
        @(posedge core_clk);
        send_req <= 1'b1;
        send_data <= w;
        @(posedge core_clk);
        send_data <= ~w;
        repeat (10) @(posedge core_clk);
        send_req <= 1'b0;
        wait_on(0);
        check("seg_on", seg_on, w);
        wait_on(1);
        check("rises", wire_bits.size(), 36);
        for (int i = 0; i < FRAME_BITS; i++)
            check("wire bit", wire_bits[i], ({w, START_BIT} >> i) & 36'h1);
    endtask

    task automatic drive_en(input logic [FRAME_BITS-1:0] f, input int nbits, input logic de);
        link_en.data_en <= de;
        for (int i = 0; i < nbits; i++)
        begin
            link_en.sdata <= f[i];
            repeat (100) @(posedge core_clk);
            link_en.sclk <= 1'b1;
            repeat (100) @(posedge core_clk);
            link_en.sclk <= 1'b0;
        end
        link_en.sdata <= ~f[nbits-1];
        repeat (100) @(posedge core_clk);
        link_en.data_en <= 1'b0;
    endtask

    // ====
    // Main sequence
    initial
    begin
        logic [DATA_BITS-1:0] w;
        link_en.sclk = 1'b0;
        link_en.sdata = 1'b0;
        link_en.data_en = 1'b0;
        repeat (8) @(posedge core_clk);
        rstn <= 1'b1;
        repeat (4) @(posedge core_clk);
        check("seg_on reset", seg_on, 36'h0);
        for (int t = 0; t < 4; t++)
        begin
            next_word(w);
            send_frame(t == 1 ? {DATA_BITS{1'b1}} : t == 2 ? 35'h0 : w);
            $display("Test frame %0d done", t);
        end
        next_word(w);
        @(posedge core_clk);
        drive_en({w, START_BIT}, 36, 1'b1);
        check("seg_on_en", seg_on_en, {1'b0, w[33:0]});
        drive_en({~w, START_BIT}, 36, 1'b0);
        check("seg_on_en off", seg_on_en, {1'b0, w[33:0]});
        drive_en({~w, START_BIT}, 10, 1'b1);
        check("seg_on_en short", seg_on_en, {1'b0, w[33:0]});
        check("loads_en", loads_en, 36'h1);
        $display("Test enable variant done");
        finish_test();
    end
endmodule

`default_nettype wire
